// [rtl/out_pin_cells.sv]
// Output pin cells: three-state pin drivers and output flip-flops
module out_pin_cells
   import pin_cell_pkg::*;
#(
   parameter int BUF_WIDTH = BUF_WIDTH_DEF,
   parameter int FAST_WIDTH = FAST_WIDTH_DEF,
   parameter int FLOP_WIDTH = FLOP_WIDTH_DEF
) (
   input wire logic CLK_SYS_IN,
   input wire logic RSTN_IN,
   input wire logic CE_IN,
   input wire pin_cell_pkg::glob_ctrl_t GLOB_CTRL_IN,
   // High-enable pin driver
   input wire logic [BUF_WIDTH-1:0] HI_EN_DATA_IN,
   input wire logic HI_EN_IN,
   output logic [BUF_WIDTH-1:0] HI_EN_PIN_OUT,
   output logic [BUF_WIDTH-1:0] HI_EN_PIN_OE_OUT,
   // Low-enable pin driver
   input wire logic [BUF_WIDTH-1:0] LO_EN_DATA_IN,
   input wire logic LO_EN_N_IN,
   output logic [BUF_WIDTH-1:0] LO_EN_PIN_OUT,
   output logic [BUF_WIDTH-1:0] LO_EN_PIN_OE_OUT,
   // Fast-enable pin driver fed by internal three-state drivers
   input wire logic [FAST_WIDTH-1:0] FAST_DATA_IN,
   input wire logic [FAST_WIDTH-1:0] FAST_DRV_OE_IN,
   input wire logic FAST_PIN_ENABLE_NET_IN,
   output logic [FAST_WIDTH-1:0] FAST_PIN_OUT,
   output logic [FAST_WIDTH-1:0] FAST_PIN_OE_OUT,
   // Plain rising-edge flops, clear type
   input wire logic [FLOP_WIDTH-1:0] RISE_D_IN,
   output logic [FLOP_WIDTH-1:0] RISE_PIN_OUT,
   // Plain falling-edge flops, clear type
   input wire logic [FLOP_WIDTH-1:0] FALL_D_IN,
   output logic [FLOP_WIDTH-1:0] FALL_PIN_OUT,
   // Gated rising-edge flops, clear type
   input wire logic [FLOP_WIDTH-1:0] GRISE_D_IN,
   input wire logic GRISE_EN_IN,
   output logic [FLOP_WIDTH-1:0] GRISE_PIN_OUT,
   output logic [FLOP_WIDTH-1:0] GRISE_PIN_OE_OUT,
   // Gated falling-edge flop, clear type
   input wire logic GFALL_D_IN,
   input wire logic GFALL_EN_IN,
   output logic GFALL_PIN_OUT,
   output logic GFALL_PIN_OE_OUT,
   // Gated rising-edge flop, preset type
   input wire logic GPRE_D_IN,
   input wire logic GPRE_EN_IN,
   output logic GPRE_PIN_OUT,
   output logic GPRE_PIN_OE_OUT,
   // Gated falling-edge flop, preset type
   input wire logic GPREF_D_IN,
   input wire logic GPREF_EN_IN,
   output logic GPREF_PIN_OUT,
   output logic GPREF_PIN_OE_OUT,
   // Plain rising-edge flop, preset type
   input wire logic PRE_D_IN,
   output logic PRE_PIN_OUT
);
   import pin_cell_pkg::*;

   logic set_clear_act;
   logic clear_force;
   logic preset_force;

   // Chip-wide forces: clear is active low, set/clear follows its polarity
   assign set_clear_act = GLOB_CTRL_IN.chip_wide_set_clear == GLOB_CTRL_IN.set_clear_pol;
   assign clear_force = !GLOB_CTRL_IN.global_clear_n || set_clear_act;
   assign preset_force = set_clear_act;

   // High-enable and low-enable drivers
   assign HI_EN_PIN_OUT = HI_EN_DATA_IN;
   assign HI_EN_PIN_OE_OUT = {BUF_WIDTH{HI_EN_IN}};
   assign LO_EN_PIN_OUT = LO_EN_DATA_IN;
   assign LO_EN_PIN_OE_OUT = {BUF_WIDTH{!LO_EN_N_IN}};

   // Fast-enable driver: pin floats if either the net or the inner driver is off
   assign FAST_PIN_OUT = FAST_DATA_IN;
   assign FAST_PIN_OE_OUT = FAST_DRV_OE_IN & {FAST_WIDTH{FAST_PIN_ENABLE_NET_IN}};

   // Plain rising-edge clear-type flops
   pin_flop #(.WIDTH(FLOP_WIDTH), .FALLING(1'b0), .PRESET(1'b0), .GATED(1'b0)) u_rise (
      .clk_in(CLK_SYS_IN), .ce_in(CE_IN), .rst_n_in(RSTN_IN),
      .async_force_in(clear_force), .d_in(RISE_D_IN), .en_in(1'b1),
      .pin_out(RISE_PIN_OUT), .pin_oe_out());

   // Plain falling-edge clear-type flops
   pin_flop #(.WIDTH(FLOP_WIDTH), .FALLING(1'b1), .PRESET(1'b0), .GATED(1'b0)) u_fall (
      .clk_in(CLK_SYS_IN), .ce_in(CE_IN), .rst_n_in(RSTN_IN),
      .async_force_in(clear_force), .d_in(FALL_D_IN), .en_in(1'b1),
      .pin_out(FALL_PIN_OUT), .pin_oe_out());

   // Gated rising-edge clear-type flops
   pin_flop #(.WIDTH(FLOP_WIDTH), .FALLING(1'b0), .PRESET(1'b0), .GATED(1'b1)) u_grise (
      .clk_in(CLK_SYS_IN), .ce_in(CE_IN), .rst_n_in(RSTN_IN),
      .async_force_in(clear_force), .d_in(GRISE_D_IN), .en_in(GRISE_EN_IN),
      .pin_out(GRISE_PIN_OUT), .pin_oe_out(GRISE_PIN_OE_OUT));

   // Gated falling-edge clear-type flop
   pin_flop #(.WIDTH(1), .FALLING(1'b1), .PRESET(1'b0), .GATED(1'b1)) u_gfall (
      .clk_in(CLK_SYS_IN), .ce_in(CE_IN), .rst_n_in(RSTN_IN),
      .async_force_in(clear_force), .d_in(GFALL_D_IN), .en_in(GFALL_EN_IN),
      .pin_out(GFALL_PIN_OUT), .pin_oe_out(GFALL_PIN_OE_OUT));

   // Gated rising-edge preset-type flop
   pin_flop #(.WIDTH(1), .FALLING(1'b0), .PRESET(1'b1), .GATED(1'b1)) u_gpre (
      .clk_in(CLK_SYS_IN), .ce_in(CE_IN), .rst_n_in(RSTN_IN),
      .async_force_in(preset_force), .d_in(GPRE_D_IN), .en_in(GPRE_EN_IN),
      .pin_out(GPRE_PIN_OUT), .pin_oe_out(GPRE_PIN_OE_OUT));

   // Gated falling-edge preset-type flop
   pin_flop #(.WIDTH(1), .FALLING(1'b1), .PRESET(1'b1), .GATED(1'b1)) u_gpref (
      .clk_in(CLK_SYS_IN), .ce_in(CE_IN), .rst_n_in(RSTN_IN),
      .async_force_in(preset_force), .d_in(GPREF_D_IN), .en_in(GPREF_EN_IN),
      .pin_out(GPREF_PIN_OUT), .pin_oe_out(GPREF_PIN_OE_OUT));

   // Plain rising-edge preset-type flop
   pin_flop #(.WIDTH(1), .FALLING(1'b0), .PRESET(1'b1), .GATED(1'b0)) u_pre (
      .clk_in(CLK_SYS_IN), .ce_in(CE_IN), .rst_n_in(RSTN_IN),
      .async_force_in(preset_force), .d_in(PRE_D_IN), .en_in(1'b1),
      .pin_out(PRE_PIN_OUT), .pin_oe_out());

   // Driver checks
   AST_HI_EN_DRIVE: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      HI_EN_PIN_OE_OUT == {BUF_WIDTH{HI_EN_IN}} && HI_EN_PIN_OUT == HI_EN_DATA_IN)
   else $error("high-enable driver wrong");

   AST_LO_EN_DRIVE: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      LO_EN_N_IN |-> LO_EN_PIN_OE_OUT == '0)
   else $error("low-enable driver drives while disabled");

   AST_FAST_FLOAT: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      FAST_PIN_ENABLE_NET_IN |-> FAST_PIN_OE_OUT == FAST_DRV_OE_IN)
   else $error("fast driver ignores internal three-state");

   AST_FAST_SHARED_EN: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      !FAST_PIN_ENABLE_NET_IN |-> FAST_PIN_OE_OUT == '0)
   else $error("fast driver drives with net low");

   AST_PRESET_HIGH: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      preset_force |-> PRE_PIN_OUT && GPRE_PIN_OUT)
   else $error("preset flop not high under set/clear");

   AST_CLEAR_LOW: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      !GLOB_CTRL_IN.global_clear_n |-> RISE_PIN_OUT == '0 && GFALL_PIN_OUT == 1'b0)
   else $error("clear flop not low under global clear");

   // Power-up load through the synchronous reset, on each cell's own edge
   AST_RISE_INIT: assert property (@(posedge CLK_SYS_IN)
      !RSTN_IN |=> RISE_PIN_OUT == '0 && GRISE_PIN_OUT == '0 && PRE_PIN_OUT && GPRE_PIN_OUT)
   else $error("rising flops not at init value after reset");

   AST_FALL_INIT: assert property (@(negedge CLK_SYS_IN)
      !RSTN_IN |=> FALL_PIN_OUT == '0 && !GFALL_PIN_OUT && GPREF_PIN_OUT)
   else $error("falling flops not at init value after reset");

   // Rising-edge loads, clock-enable freeze and driver gating
   AST_RISE_LOAD: assert property (@(posedge CLK_SYS_IN)
      disable iff (!RSTN_IN || clear_force)
      CE_IN && RSTN_IN && !clear_force |=> RISE_PIN_OUT == $past(RISE_D_IN))
   else $error("rising flop pin missed its data");

   AST_RISE_HOLD: assert property (@(posedge CLK_SYS_IN)
      disable iff (!RSTN_IN || clear_force)
      !CE_IN && RSTN_IN && !clear_force |=> RISE_PIN_OUT == $past(RISE_PIN_OUT))
   else $error("rising flop pin moved with clock enable low");

   AST_GRISE_LOAD: assert property (@(posedge CLK_SYS_IN)
      disable iff (!RSTN_IN || clear_force)
      CE_IN && RSTN_IN && !clear_force |=> GRISE_PIN_OUT == $past(GRISE_D_IN))
   else $error("gated flop did not load whatever its enable");

   AST_GRISE_GATE: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      !GRISE_EN_IN |-> GRISE_PIN_OE_OUT == '0)
   else $error("gated flop drives with enable low");

   AST_GPRE_LOAD: assert property (@(posedge CLK_SYS_IN)
      disable iff (!RSTN_IN || preset_force)
      CE_IN && RSTN_IN && !preset_force |=> GPRE_PIN_OUT == $past(GPRE_D_IN))
   else $error("gated preset flop missed its data");

   AST_GPRE_GATE: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      GPRE_PIN_OE_OUT == GPRE_EN_IN)
   else $error("gated preset flop driver does not follow enable");

   AST_PRE_LOAD: assert property (@(posedge CLK_SYS_IN)
      disable iff (!RSTN_IN || preset_force)
      CE_IN && RSTN_IN && !preset_force |=> PRE_PIN_OUT == $past(PRE_D_IN))
   else $error("plain preset flop missed its data");

   // Falling-edge loads and driver gating
   AST_FALL_LOAD: assert property (@(negedge CLK_SYS_IN)
      disable iff (!RSTN_IN || clear_force)
      CE_IN && RSTN_IN && !clear_force |=> FALL_PIN_OUT == $past(FALL_D_IN))
   else $error("falling flop pin missed its data");

   AST_GFALL_LOAD: assert property (@(negedge CLK_SYS_IN)
      disable iff (!RSTN_IN || clear_force)
      CE_IN && RSTN_IN && !clear_force |=> GFALL_PIN_OUT == $past(GFALL_D_IN))
   else $error("gated falling flop missed its data");

   AST_GFALL_GATE: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      GFALL_PIN_OE_OUT == GFALL_EN_IN)
   else $error("gated falling flop driver does not follow enable");

   AST_GPREF_LOAD: assert property (@(negedge CLK_SYS_IN)
      disable iff (!RSTN_IN || preset_force)
      CE_IN && RSTN_IN && !preset_force |=> GPREF_PIN_OUT == $past(GPREF_D_IN))
   else $error("gated falling preset flop missed its data");

   AST_GPREF_GATE: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      GPREF_PIN_OE_OUT == GPREF_EN_IN)
   else $error("gated falling preset flop driver does not follow enable");

   // Chip-wide set/clear reaches every cell of both kinds
   AST_SET_CLEAR_LOW: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      set_clear_act |-> RISE_PIN_OUT == '0 && FALL_PIN_OUT == '0 && GRISE_PIN_OUT == '0
         && !GFALL_PIN_OUT)
   else $error("clear flop not low under set/clear");

   AST_SET_PRESET_HIGH: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      preset_force |-> GPREF_PIN_OUT)
   else $error("falling preset flop not high under set/clear");

   AST_LO_EN_PASS: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      !LO_EN_N_IN |-> LO_EN_PIN_OE_OUT == '1 && LO_EN_PIN_OUT == LO_EN_DATA_IN)
   else $error("low-enable driver does not pass its data");

endmodule // out_pin_cells

// [rtl/pin_cell_pkg.sv]
// Shared types and constants for the output pin cell collection
// Contract
// - High-enable buffer drives its input while enable high, else floats the pin.
// - Fast-enable buffer passes a floating internal driver through to the pin.
// - Fast-enable buffers come one to sixteen wide, all sharing one enable.
// - Low-enable buffer drives its input while enable low, floats while high.
// - Plain flop captures data on rising edge and shows it on the pin.
// - Clear-type flops go low at power-up, global clear or global set/clear.
// - Global clear is active low; global set/clear polarity is configurable.
// - Falling-edge plain flop captures on falling edge and clears low.
// - Gated flop shows stored value while enable high, floats while low.
// - Falling-edge gated flop loads on falling edge, else as rising version.
// - Preset-type flops go high at power-up and on global set/clear.
// - Preset gated flop loads on rising edge, drives only while enable high.
// - Preset plain flop loads on rising edge with no three-state control.
// - Preset gated flop variant loading on the falling edge exists.
package pin_cell_pkg;

   // Values forced by the chip-wide clear and preset
   localparam logic FLOP_CLEAR_VAL = 1'b0;
   localparam logic FLOP_PRESET_VAL = 1'b1;

   // Default widths of the multi-bit cell families
   localparam int FAST_WIDTH_DEF = 16;
   localparam int BUF_WIDTH_DEF = 8;
   localparam int FLOP_WIDTH_DEF = 8;

   // Chip-wide reset controls
   typedef struct packed {
      logic global_clear_n;      // Global clear, active low
      logic chip_wide_set_clear; // Global set/clear request
      logic set_clear_pol;       // 1: set/clear active high, 0: active low
   } glob_ctrl_t;

endpackage : pin_cell_pkg

// [rtl/pin_flop.sv]
// One output pin flip-flop group with optional edge, preset and driver gate
module pin_flop #(
   parameter int WIDTH = 1,
   parameter bit FALLING = 1'b0,
   parameter bit PRESET = 1'b0,
   parameter bit GATED = 1'b0
) (
   input wire logic clk_in,
   input wire logic ce_in,
   input wire logic rst_n_in,
   input wire logic async_force_in,
   input wire logic [WIDTH-1:0] d_in,
   input wire logic en_in,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe_out
);
   import pin_cell_pkg::*;

   localparam logic [WIDTH-1:0] INIT_VAL = {WIDTH{PRESET ? FLOP_PRESET_VAL : FLOP_CLEAR_VAL}};

   logic [WIDTH-1:0] q_q;
   logic [WIDTH-1:0] q_d;

   // Next value: power-up reset, freeze, or load whatever the enable says
   always_comb begin
      q_d = q_q;
      if (!rst_n_in) begin
         q_d = INIT_VAL;
      end else if (ce_in) begin
         q_d = d_in;
      end
   end

   // Register on the chosen edge, with asynchronous force
   generate
      if (FALLING) begin : g_fall
         always_ff @(negedge clk_in or posedge async_force_in) begin
            if (async_force_in) begin
               q_q <= INIT_VAL;
            end else begin
               q_q <= q_d;
            end
         end

         // Only edges that really load are checked: reset and force sampled off
         AST_FALL_CAPTURE: assert property (@(negedge clk_in)
            disable iff (async_force_in || !rst_n_in)
            ce_in && rst_n_in && !async_force_in |=> q_q == $past(d_in))
         else $error("falling flop missed its data");
      end else begin : g_rise
         always_ff @(posedge clk_in or posedge async_force_in) begin
            if (async_force_in) begin
               q_q <= INIT_VAL;
            end else begin
               q_q <= q_d;
            end
         end

         // A reset release or force release on the edge itself still loads init
         AST_RISE_CAPTURE: assert property (@(posedge clk_in)
            disable iff (async_force_in || !rst_n_in)
            ce_in && rst_n_in && !async_force_in |=> q_q == $past(d_in))
         else $error("rising flop missed its data");
      end
   endgenerate

   // Pin data and driver enable; enable never touches the stored value
   assign pin_out = q_q;
   assign pin_oe_out = GATED ? {WIDTH{en_in}} : {WIDTH{1'b1}};

   AST_FORCE_VALUE: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      async_force_in |-> q_q == INIT_VAL)
   else $error("forced flop does not hold its init value");

   AST_GATE_DRIVER: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      pin_oe_out == (GATED ? {WIDTH{en_in}} : {WIDTH{1'b1}}))
   else $error("driver enable does not follow the gate");

   AST_LOAD_WHEN_OFF: assert property (@(posedge clk_in)
      disable iff (async_force_in || !rst_n_in || FALLING)
      ce_in && rst_n_in && !async_force_in && !en_in |=> q_q == $past(d_in))
   else $error("flop stopped loading while driver was off");

endmodule // pin_flop

// [tb/pin_far_end.sv]
// Far-end pin model: the level an outside device sees on each pin
module pin_far_end #(
   parameter int WIDTH = 8
) (
   input wire logic [WIDTH-1:0] pin_in,
   input wire logic [WIDTH-1:0] oe_in,
   output logic [WIDTH-1:0] lvl_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // A released pin falls to the board pull-up, never the stale value
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         lvl_out[i] = oe_in[i] ? pin_in[i] : 1'b1;
      end
   end
endmodule // pin_far_end

// [tb/tb_out_pin_cells.sv]
// Self-checking bench for the output pin drivers and output flops
module tb_out_pin_cells;
   timeunit 1ns;
   timeprecision 1ps;
   import pin_cell_pkg::*;
   logic CLK_SYS_IN = 1'b0, RSTN_IN = 1'b0, CE_IN = 1'b1;
   glob_ctrl_t GLOB_CTRL_IN = 3'h5;
   logic [7:0] HI_EN_DATA_IN = 8'h00, LO_EN_DATA_IN = 8'h00, RISE_D_IN = 8'h00;
   logic [7:0] FALL_D_IN = 8'h00, GRISE_D_IN = 8'h00;
   logic HI_EN_IN = 1'b0, LO_EN_N_IN = 1'b1, GRISE_EN_IN = 1'b0, FAST_PIN_ENABLE_NET_IN = 1'b0;
   logic GFALL_D_IN = 1'b0, GFALL_EN_IN = 1'b0, GPRE_D_IN = 1'b0, GPRE_EN_IN = 1'b0;
   logic GPREF_D_IN = 1'b1, GPREF_EN_IN = 1'b0, PRE_D_IN = 1'b0;
   logic [15:0] FAST_DATA_IN = 16'h0000, FAST_DRV_OE_IN = 16'h0000;
   logic [7:0] HI_EN_PIN_OUT, HI_EN_PIN_OE_OUT, LO_EN_PIN_OUT, LO_EN_PIN_OE_OUT;
   logic [7:0] RISE_PIN_OUT, FALL_PIN_OUT, GRISE_PIN_OUT, GRISE_PIN_OE_OUT;
   logic [15:0] FAST_PIN_OUT, FAST_PIN_OE_OUT, fast_lvl;
   logic GFALL_PIN_OUT, GFALL_PIN_OE_OUT, GPRE_PIN_OUT, GPRE_PIN_OE_OUT;
   logic GPREF_PIN_OUT, GPREF_PIN_OE_OUT, PRE_PIN_OUT;
   logic [7:0] hi_lvl, lo_lvl, gr_lvl;
   int err_total = 0, compares = 0, cycles = 0;

   // Block under test and the outside world on its three-state pins
   out_pin_cells out_pin_cells_inst (.CLK_SYS_IN, .RSTN_IN, .CE_IN, .GLOB_CTRL_IN,
      .HI_EN_DATA_IN, .HI_EN_IN, .HI_EN_PIN_OUT, .HI_EN_PIN_OE_OUT, .LO_EN_DATA_IN,
      .LO_EN_N_IN, .LO_EN_PIN_OUT, .LO_EN_PIN_OE_OUT, .FAST_DATA_IN, .FAST_DRV_OE_IN,
      .FAST_PIN_ENABLE_NET_IN, .FAST_PIN_OUT, .FAST_PIN_OE_OUT, .RISE_D_IN, .RISE_PIN_OUT,
      .FALL_D_IN, .FALL_PIN_OUT, .GRISE_D_IN, .GRISE_EN_IN, .GRISE_PIN_OUT, .GRISE_PIN_OE_OUT,
      .GFALL_D_IN, .GFALL_EN_IN, .GFALL_PIN_OUT, .GFALL_PIN_OE_OUT, .GPRE_D_IN, .GPRE_EN_IN,
      .GPRE_PIN_OUT, .GPRE_PIN_OE_OUT, .GPREF_D_IN, .GPREF_EN_IN, .GPREF_PIN_OUT,
      .GPREF_PIN_OE_OUT, .PRE_D_IN, .PRE_PIN_OUT);
   pin_far_end #(.WIDTH(8)) hi_far_inst (.pin_in(HI_EN_PIN_OUT), .oe_in(HI_EN_PIN_OE_OUT),
      .lvl_out(hi_lvl));
   pin_far_end #(.WIDTH(8)) lo_far_inst (.pin_in(LO_EN_PIN_OUT), .oe_in(LO_EN_PIN_OE_OUT),
      .lvl_out(lo_lvl));
   pin_far_end #(.WIDTH(8)) gr_far_inst (.pin_in(GRISE_PIN_OUT), .oe_in(GRISE_PIN_OE_OUT),
      .lvl_out(gr_lvl));
   pin_far_end #(.WIDTH(16)) fast_far_inst (.pin_in(FAST_PIN_OUT), .oe_in(FAST_PIN_OE_OUT),
      .lvl_out(fast_lvl));

   // Clock and hang guard
   always #25 CLK_SYS_IN = ~CLK_SYS_IN;
   always @(posedge CLK_SYS_IN) begin
      cycles++;
      if (cycles == 500) begin
         err_total++;
         finish_test();
      end
   end

   task automatic tick();
      @(posedge CLK_SYS_IN);
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      if (err_total == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Both enable polarities and the fast net, off then on
   task automatic t_drivers();
      for (int e = 0; e < 2; e++) begin
         tick();
         HI_EN_IN <= e[0];
         LO_EN_N_IN <= !e[0];
         HI_EN_DATA_IN <= 8'hA5;
         LO_EN_DATA_IN <= 8'h3C;
         FAST_DATA_IN <= 16'h5A3C;
         FAST_DRV_OE_IN <= 16'hF0F0;
         FAST_PIN_ENABLE_NET_IN <= e[0]; // the fast net enables only pins whose FAST_DRV_OE_IN bit is set
         #1;
         chk(hi_lvl, e ? 16'h00A5 : 16'h00FF);
         chk(lo_lvl, e ? 16'h003C : 16'h00FF);
         chk(fast_lvl, e ? 16'h5F3F : 16'hFFFF);
      end
   endtask

   // Rising cells load with the driver gate low, then drive when opened
   task automatic t_rise();
      tick();
      RISE_D_IN <= 8'hC3;
      GRISE_D_IN <= 8'h5A;
      tick();
      #1;
      chk(RISE_PIN_OUT, 16'h00C3);
      chk({GRISE_PIN_OUT, gr_lvl}, 16'h5AFF);
      chk({PRE_PIN_OUT, GPRE_PIN_OUT, GPRE_PIN_OE_OUT}, 16'h0000);
      tick();
      GRISE_EN_IN <= 1'b1;
      GPRE_EN_IN <= 1'b1;
      GPRE_D_IN <= 1'b1;
      #1;
      chk(gr_lvl, 16'h005A);
      chk({GPRE_PIN_OUT, GPRE_PIN_OE_OUT}, 16'h0001);
   endtask

   // Falling cells change only at the falling edge
   task automatic t_fall();
      tick();
      FALL_D_IN <= 8'h96;
      GFALL_D_IN <= 1'b1;
      GFALL_EN_IN <= 1'b1;
      GPREF_D_IN <= 1'b0;
      GPREF_EN_IN <= 1'b1;
      RISE_D_IN <= 8'h11;
      #1;
      chk({FALL_PIN_OUT, GFALL_PIN_OUT, GPREF_PIN_OUT}, 16'h0001);
      @(negedge CLK_SYS_IN);
      #1;
      chk(FALL_PIN_OUT, 16'h0096);
      chk({GFALL_PIN_OUT, GFALL_PIN_OE_OUT, GPREF_PIN_OUT, GPREF_PIN_OE_OUT}, 16'h000D);
      chk(RISE_PIN_OUT, 16'h00C3);
   endtask

   // Clock enable low freezes the flops
   task automatic t_ce();
      tick();
      CE_IN <= 1'b0;
      RISE_D_IN <= 8'hFF;
      FALL_D_IN <= 8'h69;
      tick();
      #1;
      chk({FALL_PIN_OUT, RISE_PIN_OUT}, 16'h9611);
      tick();
      CE_IN <= 1'b1;
      RISE_D_IN <= 8'h11;
   endtask

   // Chip-wide clear and set/clear at both polarities, applied at clock edges
   task automatic t_glob();
      tick();
      GLOB_CTRL_IN <= 3'h4;
      #1;
      chk({FALL_PIN_OUT, RISE_PIN_OUT}, 16'h0000);
      chk({PRE_PIN_OUT, GPREF_PIN_OUT}, 16'h0003);
      tick();
      GLOB_CTRL_IN <= 3'h5;
      tick();
      #1;
      chk(RISE_PIN_OUT, 16'h0011);
      tick();
      GLOB_CTRL_IN <= 3'h1;
      #1;
      chk({RISE_PIN_OUT, GRISE_PIN_OUT}, 16'h0000);
      chk({PRE_PIN_OUT, GPREF_PIN_OUT}, 16'h0000);
      tick();
      GLOB_CTRL_IN <= 3'h7;
      #1;
      chk({PRE_PIN_OUT, GPREF_PIN_OUT}, 16'h0003);
      tick();
      GLOB_CTRL_IN <= 3'h5;
   endtask

   // Main sequence
   initial begin
      repeat (20) tick();
      #1;
      chk({FALL_PIN_OUT, RISE_PIN_OUT}, 16'h0000);
      chk(GRISE_PIN_OUT, 16'h0000);
      chk({GFALL_PIN_OUT, GPRE_PIN_OUT, GPREF_PIN_OUT, PRE_PIN_OUT}, 16'h0007);
      tick();
      RSTN_IN <= 1'b1;
      t_drivers();
      t_rise();
      t_fall();
      t_ce();
      t_glob();
      finish_test();
   end
endmodule // tb_out_pin_cells
